/* File: verilog/rfr_reg_map.sv */
// Purpose: host-visible control and status register bank
// Assumes: host pins asynchronous to clk; core status inputs on clk
// Notes:   one word per rising host_strobe while host_sel is high
`timescale 1ns/1ps
module rfr_reg_map #(
	parameter int STARTUP_CYCLES = rfr_pkg::STARTUP_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   chip_enable,
	input  wire logic                   host_sel,
	input  wire logic                   host_strobe,
	input  wire logic [7:0]             host_data,
	input  wire logic [7:0]             irq_flags,
	input  wire logic [7:0]             collision_pos,
	input  wire logic                   collision_load,
	input  wire logic [7:0]             strength_osc,
	input  wire logic [7:0]             queue_state,
	input  wire logic                   queue_state_load,
	output logic [7:0]                  host_rdata,
	output rfr_pkg::rfr_chip_state_s    chip_state,
	output logic                        receiver_enable,
	output logic                        full_operation,
	output logic [7:0]                  protocol_select,
	output logic [15:0]                 tx_timer,
	output logic [7:0]                  tx_pulse_length,
	output logic [7:0]                  mod_clock_control,
	output logic [7:0]                  rx_special,
	output logic [7:0]                  regulator_io,
	output logic                        reset_cmd
);

	logic [7:0]              regs_ff [0:31];
	logic                    en_s1_ff, en_s2_ff;
	logic                    sel_s1_ff, sel_s2_ff;
	logic                    stb_s1_ff, stb_s2_ff, stb_s3_ff;
	logic [7:0]              dat_s1_ff, dat_s2_ff;
	logic [7:0]              coll_ff, qstat_ff;
	logic [7:0]              rdata_ff;
	logic                    rx_en_ff, full_op_ff, rst_cmd_ff;
	logic                    stby_d_ff;
	logic [31:0]             start_cnt_ff;
	logic                    counting_ff;
	logic [4:0]              addr_ff;
	logic                    read_ff, cont_ff;
	rfr_pkg::rfr_phase_e     phase_ff;
	rfr_pkg::rfr_host_word_s word;
	logic                    take;
	logic                    take_wr;
	logic [4:0]              nxt_addr;

	function automatic logic is_ro(input logic [4:0] a);
		is_ro = (a == rfr_pkg::ADR_IRQ) || (a == rfr_pkg::ADR_COLL) ||
			(a == rfr_pkg::ADR_LEVEL) || (a == rfr_pkg::ADR_QSTAT);
	endfunction

	function automatic logic is_rw(input logic [4:0] a);
		is_rw = ((a <= rfr_pkg::ADR_REGIO) || (a == rfr_pkg::ADR_CMASK) ||
			(a >= rfr_pkg::ADR_TSTA)) && !is_ro(a);
	endfunction

	// irq and strength read straight from core inputs, collision and queue state from captured copies, unmapped read zero
	function automatic logic [7:0] rd_value(input logic [4:0] a);
		if (a == rfr_pkg::ADR_IRQ)
			rd_value = irq_flags;
		else if (a == rfr_pkg::ADR_COLL)
			rd_value = coll_ff;
		else if (a == rfr_pkg::ADR_LEVEL)
			rd_value = strength_osc;
		else if (a == rfr_pkg::ADR_QSTAT)
			rd_value = qstat_ff;
		else if (is_rw(a))
			rd_value = regs_ff[a];
		else
			rd_value = 8'h00;
	endfunction

	// host pins cross in via two flops each
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_s1_ff  <= 1'b0;
			en_s2_ff  <= 1'b0;
			sel_s1_ff <= 1'b0;
			sel_s2_ff <= 1'b0;
			stb_s1_ff <= 1'b0;
			stb_s2_ff <= 1'b0;
			stb_s3_ff <= 1'b0;
			dat_s1_ff <= 8'h00;
			dat_s2_ff <= 8'h00;
		end else begin
			en_s1_ff  <= chip_enable;
			en_s2_ff  <= en_s1_ff;
			sel_s1_ff <= host_sel;
			sel_s2_ff <= sel_s1_ff;
			stb_s1_ff <= host_strobe;
			stb_s2_ff <= stb_s1_ff;
			stb_s3_ff <= stb_s2_ff;
			dat_s1_ff <= host_data;
			dat_s2_ff <= dat_s1_ff;
		end
	end

	assign word     = dat_s2_ff;
	assign take     = sel_s2_ff && stb_s2_ff && !stb_s3_ff;
	assign take_wr  = take && (phase_ff == rfr_pkg::RFR_DATA) && !read_ff;
	assign nxt_addr = addr_ff + 5'h01;

	// word framing: first word is address or command
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_ff <= rfr_pkg::RFR_WAIT_ADDR;
			addr_ff  <= 5'h00;
			read_ff  <= 1'b0;
			cont_ff  <= 1'b0;
		end else if (!sel_s2_ff) begin
			phase_ff <= rfr_pkg::RFR_WAIT_ADDR;
		end else if (take) begin
			case (phase_ff)
				rfr_pkg::RFR_WAIT_ADDR: begin
					// commands take no data words
					if (word.is_cmd) begin
						phase_ff <= rfr_pkg::RFR_DONE;
					end else begin
						phase_ff <= rfr_pkg::RFR_DATA;
						addr_ff  <= word.field;
						read_ff  <= word.is_read;
						cont_ff  <= word.continuous;
					end
				end
				rfr_pkg::RFR_DATA: begin
					if (cont_ff)
						addr_ff <= nxt_addr;
					else
						phase_ff <= rfr_pkg::RFR_DONE;
				end
				default: phase_ff <= phase_ff;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rst_cmd_ff <= 1'b0;
		else
			rst_cmd_ff <= take && (phase_ff == rfr_pkg::RFR_WAIT_ADDR) &&
				word.is_cmd && (word.field == rfr_pkg::CMD_RESET);
	end

	// read data leads the next strobe; continuous reads walk forward
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata_ff <= 8'h00;
		else if (take && (phase_ff == rfr_pkg::RFR_WAIT_ADDR) &&
			!word.is_cmd)
			rdata_ff <= rd_value(word.field);
		else if (take && (phase_ff == rfr_pkg::RFR_DATA) && cont_ff)
			rdata_ff <= rd_value(nxt_addr);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			coll_ff  <= 8'h00;
			qstat_ff <= 8'h00;
		end else begin
			// a fresh load in the clear cycle wins, so no event is lost
			if (collision_load)
				coll_ff <= collision_pos;
			else if (rst_cmd_ff)
				coll_ff <= 8'h00;
			if (queue_state_load)
				qstat_ff <= queue_state;
			else if (rst_cmd_ff)
				qstat_ff <= 8'h00;
		end
	end

	// read-only and unmapped slots are never written
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 32; i++)
				regs_ff[i] <= rfr_pkg::OTHER_RST;
			regs_ff[rfr_pkg::ADR_CSC]  <= rfr_pkg::CSC_RST;
			regs_ff[rfr_pkg::ADR_PSEL] <= rfr_pkg::PSEL_RST;
		end else if (!en_s2_ff) begin
			regs_ff[rfr_pkg::ADR_CSC]  <= rfr_pkg::CSC_RST;
			regs_ff[rfr_pkg::ADR_PSEL] <= rfr_pkg::PSEL_RST;
		end else if (take_wr && is_rw(addr_ff)) begin
			regs_ff[addr_ff] <= dat_s2_ff;
		end
	end

	// standby exit starts the settle count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stby_d_ff    <= 1'b0;
			counting_ff  <= 1'b0;
			start_cnt_ff <= 32'h0;
			full_op_ff   <= 1'b0;
		end else begin
			stby_d_ff <= chip_state.standby;
			if (chip_state.standby) begin
				counting_ff  <= 1'b0;
				full_op_ff   <= 1'b0;
			end else if (stby_d_ff || (!full_op_ff && !counting_ff)) begin
				counting_ff  <= 1'b1;
				start_cnt_ff <= 32'h0;
			end else if (counting_ff) begin
				if (start_cnt_ff == 32'(STARTUP_CYCLES - 1)) begin
					counting_ff <= 1'b0;
					full_op_ff  <= 1'b1;
				end else begin
					start_cnt_ff <= start_cnt_ff + 32'h1;
				end
			end
		end
	end

	// receiver follows carrier bit unless forced for field measurement
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rx_en_ff <= 1'b0;
		else
			rx_en_ff <= chip_state.receiver_force_on ||
				chip_state.carrier_output_enable;
	end

	// fields drive the front end directly
	assign chip_state        = regs_ff[rfr_pkg::ADR_CSC];
	assign protocol_select   = regs_ff[rfr_pkg::ADR_PSEL];
	assign tx_timer          = {regs_ff[rfr_pkg::ADR_TXH],
		regs_ff[rfr_pkg::ADR_TXL]};
	assign tx_pulse_length   = regs_ff[rfr_pkg::ADR_PULSE];
	assign mod_clock_control = regs_ff[rfr_pkg::ADR_MOD];
	assign rx_special        = regs_ff[rfr_pkg::ADR_RXSP];
	assign regulator_io      = regs_ff[rfr_pkg::ADR_REGIO];
	assign host_rdata        = rdata_ff;
	assign receiver_enable   = rx_en_ff;
	assign full_operation    = full_op_ff;
	assign reset_cmd         = rst_cmd_ff;

	csc_reset_a: assert property (@(posedge clk) disable iff (!rstn)
		!en_s2_ff |=> regs_ff[rfr_pkg::ADR_CSC] == 8'h01 &&
			regs_ff[rfr_pkg::ADR_PSEL] == 8'h02)
		else $error("chip state not preset while disabled");

	standby_drop_a: assert property (@(posedge clk) disable iff (!rstn)
		chip_state.standby |=> !full_op_ff)
		else $error("full operation shown in standby");

	startup_time_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(full_op_ff) |->
			$past(start_cnt_ff) == 32'(STARTUP_CYCLES - 1) &&
			$past(counting_ff))
		else $error("full operation before settle count");

	rx_enable_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(chip_state.carrier_output_enable) ##1
			chip_state.carrier_output_enable |-> rx_en_ff)
		else $error("receiver not enabled by carrier bit");

	timer_write_a: assert property (@(posedge clk) disable iff (!rstn)
		take_wr && en_s2_ff && addr_ff == rfr_pkg::ADR_TXL |=>
			tx_timer[7:0] == $past(dat_s2_ff))
		else $error("timer low byte not written");

	ro_ignore_a: assert property (@(posedge clk) disable iff (!rstn)
		regs_ff[rfr_pkg::ADR_IRQ] == 8'h00 &&
			regs_ff[rfr_pkg::ADR_COLL] == 8'h00 &&
			regs_ff[rfr_pkg::ADR_LEVEL] == 8'h00 &&
			regs_ff[rfr_pkg::ADR_QSTAT] == 8'h00)
		else $error("read-only slot written");

	cont_incr_a: assert property (@(posedge clk) disable iff (!rstn)
		take && sel_s2_ff && phase_ff == rfr_pkg::RFR_DATA && cont_ff |=>
			addr_ff == $past(nxt_addr) && phase_ff == rfr_pkg::RFR_DATA)
		else $error("continuous address did not advance");

	single_done_a: assert property (@(posedge clk) disable iff (!rstn)
		take && sel_s2_ff && phase_ff == rfr_pkg::RFR_DATA && !cont_ff |=>
			phase_ff == rfr_pkg::RFR_DONE)
		else $error("single access did not finish");

	level_read_a: assert property (@(posedge clk) disable iff (!rstn)
		take && phase_ff == rfr_pkg::RFR_WAIT_ADDR && !word.is_cmd &&
			word.field == rfr_pkg::ADR_LEVEL |=>
			rdata_ff == $past(strength_osc))
		else $error("strength read wrong");

	mask_read_a: assert property (@(posedge clk) disable iff (!rstn)
		take && phase_ff == rfr_pkg::RFR_WAIT_ADDR && !word.is_cmd &&
			word.field == rfr_pkg::ADR_CMASK |=>
			rdata_ff == $past(regs_ff[rfr_pkg::ADR_CMASK]))
		else $error("mask register read wrong");

	csc_write_a: assert property (@(posedge clk) disable iff (!rstn)
		take_wr && en_s2_ff && addr_ff == rfr_pkg::ADR_CSC |=>
			chip_state == $past(dat_s2_ff))
		else $error("chip state write lost");

	rx_force_a: assert property (@(posedge clk) disable iff (!rstn)
		chip_state.receiver_force_on |=> rx_en_ff)
		else $error("receiver not forced on");

	rx_off_a: assert property (@(posedge clk) disable iff (!rstn)
		!chip_state.receiver_force_on &&
			!chip_state.carrier_output_enable |=> !rx_en_ff)
		else $error("receiver on without carrier or force");

	ro_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		take_wr && addr_ff == rfr_pkg::ADR_COLL && !collision_load &&
			!rst_cmd_ff |=> coll_ff == $past(coll_ff))
		else $error("collision position changed by host write");

	cmd_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		rst_cmd_ff && !queue_state_load |=> qstat_ff == 8'h00)
		else $error("queue state not cleared by command");

	enable_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		!en_s2_ff |=> tx_timer == $past(tx_timer))
		else $error("timer changed while disabled");

endmodule

/* File: verilog/rfr_pkg.sv */
// Purpose: constants and carriers for the reader front end register map
// Assumes: 5-bit register address space, byte-wide registers
// Notes:   host word is cmd/read/continuous flags over a 5-bit field
package rfr_pkg;

	localparam logic [4:0] ADR_CSC   = 5'h00;
	localparam logic [4:0] ADR_PSEL  = 5'h01;
	localparam logic [4:0] ADR_TYB   = 5'h02;
	localparam logic [4:0] ADR_TYA   = 5'h03;
	localparam logic [4:0] ADR_TXH   = 5'h04;
	localparam logic [4:0] ADR_TXL   = 5'h05;
	localparam logic [4:0] ADR_PULSE = 5'h06;
	localparam logic [4:0] ADR_NORSP = 5'h07;
	localparam logic [4:0] ADR_RXW   = 5'h08;
	localparam logic [4:0] ADR_MOD   = 5'h09;
	localparam logic [4:0] ADR_RXSP  = 5'h0a;
	localparam logic [4:0] ADR_REGIO = 5'h0b;
	localparam logic [4:0] ADR_IRQ   = 5'h0c;
	localparam logic [4:0] ADR_CMASK = 5'h0d;
	localparam logic [4:0] ADR_COLL  = 5'h0e;
	localparam logic [4:0] ADR_LEVEL = 5'h0f;
	localparam logic [4:0] ADR_TSTA  = 5'h1a;
	localparam logic [4:0] ADR_TSTB  = 5'h1b;
	localparam logic [4:0] ADR_QSTAT = 5'h1c;
	localparam logic [4:0] ADR_LEN1  = 5'h1d;
	localparam logic [4:0] ADR_LEN2  = 5'h1e;
	localparam logic [4:0] ADR_QDATA = 5'h1f;

	localparam logic [7:0] CSC_RST   = 8'h01;
	localparam logic [7:0] PSEL_RST  = 8'h02;
	localparam logic [7:0] OTHER_RST = 8'h00;

	// command code that clears collision position and queue state
	localparam logic [4:0] CMD_RESET = 5'h0f;

	localparam int STARTUP_US  = 100;
	localparam int CLK_MHZ     = 125;
	localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;

	typedef struct packed {
		logic standby;
		logic direct_mode;
		logic carrier_output_enable;
		logic output_strength_halve;
		logic aux_input_select;
		logic agc_enable;
		logic receiver_force_on;
		logic supply_5v_select;
	} rfr_chip_state_s;

	typedef struct packed {
		logic       is_cmd;
		logic       is_read;
		logic       continuous;
		logic [4:0] field;
	} rfr_host_word_s;

	typedef enum {
		RFR_WAIT_ADDR,
		RFR_DATA,
		RFR_DONE
	} rfr_phase_e;

endpackage

/* File: tb/rfr_host_model.sv */
// Purpose: host controller model driving the word-per-strobe host port
// Assumes: inputs change at falling clk edges, words framed by host_sel
// Notes:   setup, hold and strobe widths kept at four cycles each
`timescale 1ns/1ps
module rfr_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] host_rdata,
	output logic            host_sel,
	output logic            host_strobe,
	output logic [7:0]      host_data
);
	initial begin
		host_sel = 1'b0;
		host_strobe = 1'b0;
		host_data = 8'h00;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic open_frame();
		gap(1);
		host_sel = 1'b1;
		gap(4);
	endtask
	task automatic close_frame();
		host_sel = 1'b0;
		gap(4);
	endtask
	// released bus shows the inverse, never a stale copy of the word
	task automatic send_word(input logic [7:0] w);
		host_data = w;
		gap(4);
		host_strobe = 1'b1;
		gap(4);
		host_strobe = 1'b0;
		gap(4);
		host_data = ~w;
	endtask
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
		open_frame();
		send_word({3'b000, a});
		send_word(d);
		close_frame();
	endtask
	task automatic write_cont(input logic [4:0] a, input logic [15:0] d);
		open_frame();
		send_word({3'b001, a});
		send_word(d[15:8]);
		send_word(d[7:0]);
		close_frame();
	endtask
	task automatic read_reg(input logic [4:0] a, output logic [7:0] v);
		open_frame();
		send_word({3'b010, a});
		v = host_rdata;
		close_frame();
	endtask
	// first data strobe of a continuous read moves to the next address
	task automatic read_cont(input logic [4:0] a, output logic [15:0] v);
		open_frame();
		send_word({3'b011, a});
		v[15:8] = host_rdata;
		send_word(8'h00);
		v[7:0] = host_rdata;
		close_frame();
	endtask
	task automatic command(input logic [4:0] c);
		open_frame();
		send_word({3'b100, c});
		close_frame();
	endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the register bank through the host port
// Assumes: shortened startup count, core status inputs held by the bench
// Notes:   expectations come from the register map, not from the design
`timescale 1ns/1ps
module testbench;
	localparam int SU = 20;
	logic                     clk;
	logic                     rstn;
	logic                     chip_enable;
	logic                     host_sel;
	logic                     host_strobe;
	logic [7:0]               host_data;
	logic [7:0]               irq_flags;
	logic [7:0]               collision_pos;
	logic                     collision_load;
	logic [7:0]               strength_osc;
	logic [7:0]               queue_state;
	logic                     queue_state_load;
	logic [7:0]               host_rdata;
	rfr_pkg::rfr_chip_state_s chip_state;
	logic                     receiver_enable;
	logic                     full_operation;
	logic [7:0]               protocol_select;
	logic [15:0]              tx_timer;
	logic [7:0]               tx_pulse_length;
	logic [7:0]               mod_clock_control;
	logic [7:0]               rx_special;
	logic [7:0]               regulator_io;
	logic                     reset_cmd;
	int                       mismatches = 0;
	int                       checked = 0;
	int                       cycles = 0;
	int                       pulses = 0;
	logic [7:0]               v;
	logic [15:0]              w;
	logic [4:0]               rw_adr [8];

	rfr_reg_map #(.STARTUP_CYCLES(SU)) i_rfr_reg_map (
		.clk(clk), .rstn(rstn), .chip_enable(chip_enable),
		.host_sel(host_sel), .host_strobe(host_strobe),
		.host_data(host_data), .irq_flags(irq_flags),
		.collision_pos(collision_pos), .collision_load(collision_load),
		.strength_osc(strength_osc), .queue_state(queue_state),
		.queue_state_load(queue_state_load), .host_rdata(host_rdata),
		.chip_state(chip_state), .receiver_enable(receiver_enable),
		.full_operation(full_operation),
		.protocol_select(protocol_select), .tx_timer(tx_timer),
		.tx_pulse_length(tx_pulse_length),
		.mod_clock_control(mod_clock_control), .rx_special(rx_special),
		.regulator_io(regulator_io), .reset_cmd(reset_cmd)
	);
	rfr_host_model i_rfr_host_model (
		.clk(clk), .host_rdata(host_rdata), .host_sel(host_sel),
		.host_strobe(host_strobe), .host_data(host_data)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic print_verdict();
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard sized well above the roughly 1200 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (reset_cmd === 1'b1)
			pulses++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] r;
		i_rfr_host_model.read_reg(a, r);
		check(r, exp);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		i_rfr_host_model.write_reg(a, d);
	endtask

	initial begin
		rstn = 1'b0;
		chip_enable = 1'b0;
		irq_flags = 8'h5c;
		collision_pos = 8'h3c;
		collision_load = 1'b0;
		strength_osc = 8'ha7;
		queue_state = 8'h9e;
		queue_state_load = 1'b0;
		rw_adr = '{rfr_pkg::ADR_TXH, rfr_pkg::ADR_TXL, rfr_pkg::ADR_PULSE,
			rfr_pkg::ADR_MOD, rfr_pkg::ADR_RXSP, rfr_pkg::ADR_REGIO,
			rfr_pkg::ADR_CMASK, rfr_pkg::ADR_TSTA};
		repeat (5) @(negedge clk);
		check(chip_state, 8'h01);
		check(protocol_select, 8'h02);
		rstn = 1'b1;
		chip_enable = 1'b1;
		repeat (8) @(negedge clk);
		rd_chk(rfr_pkg::ADR_CSC, 8'h01);
		wr(rfr_pkg::ADR_PSEL, 8'h42);
		check(protocol_select, 8'h42);
		for (int b = 1; b < 8; b++) begin
			v = 8'h01 << b;
			wr(rfr_pkg::ADR_CSC, v);
			check(chip_state, v);
			check(receiver_enable, (b == 5) || (b == 1));
		end
		check(full_operation, 1'b0);
		wr(rfr_pkg::ADR_CSC, 8'h00);
		check(full_operation, 1'b0);
		repeat (SU + 6) @(negedge clk);
		check(full_operation, 1'b1);
		for (int i = 0; i < 8; i++)
			wr(rw_adr[i], 8'h30 + i);
		for (int i = 0; i < 8; i++)
			rd_chk(rw_adr[i], 8'h30 + i);
		check(tx_timer, 16'h3031);
		check(tx_pulse_length, 8'h32);
		check(mod_clock_control, 8'h33);
		check(rx_special, 8'h34);
		check(regulator_io, 8'h35);
		i_rfr_host_model.write_cont(rfr_pkg::ADR_TXH, 16'h1122);
		check(tx_timer, 16'h1122);
		i_rfr_host_model.read_cont(rfr_pkg::ADR_TXH, w);
		check(w, 16'h1122);
		@(negedge clk);
		collision_load = 1'b1;
		queue_state_load = 1'b1;
		@(negedge clk);
		collision_load = 1'b0;
		queue_state_load = 1'b0;
		wr(rfr_pkg::ADR_COLL, 8'hff);
		wr(rfr_pkg::ADR_QSTAT, 8'hff);
		wr(rfr_pkg::ADR_LEVEL, 8'h00);
		wr(5'h12, 8'h77);
		rd_chk(rfr_pkg::ADR_COLL, 8'h3c);
		rd_chk(rfr_pkg::ADR_QSTAT, 8'h9e);
		rd_chk(rfr_pkg::ADR_LEVEL, 8'ha7);
		rd_chk(rfr_pkg::ADR_IRQ, 8'h5c);
		rd_chk(5'h12, 8'h00);
		i_rfr_host_model.command(rfr_pkg::CMD_RESET);
		check(pulses, 16'h0001);
		rd_chk(rfr_pkg::ADR_COLL, 8'h00);
		rd_chk(rfr_pkg::ADR_QSTAT, 8'h00);
		chip_enable = 1'b0;
		repeat (6) @(negedge clk);
		check(chip_state, 8'h01);
		check(protocol_select, 8'h02);
		check(tx_timer, 16'h1122);
		print_verdict();
	end
endmodule
